// File: hdl/pbd_pkg.sv
// Shared constants and types for the programmable byte datapath
package pbd_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_A0     = 8'h00;
  localparam logic [7:0] OFS_A1     = 8'h04;
  localparam logic [7:0] OFS_D0     = 8'h08;
  localparam logic [7:0] OFS_D1     = 8'h0c;
  localparam logic [7:0] OFS_F0     = 8'h10;
  localparam logic [7:0] OFS_F1     = 8'h14;
  localparam logic [7:0] OFS_CTL    = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1c;
  localparam logic [7:0] OFS_POLY   = 8'h20;
  localparam logic [7:0] OFS_OUTSEL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_OPCFG  = 8'h40;  // 8 words, 0x40..0x5c

  // ------------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------------
  localparam int unsigned NUM_OPS   = 8;
  localparam int unsigned NUM_OUT   = 6;
  localparam int unsigned FIFO_DEP  = 4;
  localparam logic [2:0]  MSB_RST   = 3'h7;
  localparam logic [7:0]  AMASK_RST = 8'hff;
  localparam logic [7:0]  ONES8     = 8'hff;

  // Condition vector positions
  localparam int unsigned CN_CE0 = 0;
  localparam int unsigned CN_CL0 = 1;
  localparam int unsigned CN_Z0  = 2;
  localparam int unsigned CN_Z1  = 3;
  localparam int unsigned CN_FF0 = 4;
  localparam int unsigned CN_FF1 = 5;
  localparam int unsigned CN_CE1 = 6;
  localparam int unsigned CN_CL1 = 7;
  localparam int unsigned CN_OV  = 8;
  localparam int unsigned CN_CO  = 9;
  localparam int unsigned CN_SO  = 10;
  localparam int unsigned CN_F0E = 11;
  localparam int unsigned CN_F0F = 12;
  localparam int unsigned CN_F1E = 13;
  localparam int unsigned CN_F1F = 14;
  localparam int unsigned CN_FB  = 15;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_PASS, FN_INC, FN_DEC, FN_ADD, FN_SUB, FN_XOR, FN_AND, FN_OR
  } pbd_func_t;

  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} pbd_shift_t;

  // One operation word, picked each cycle by the routing inputs
  typedef struct packed {
    logic       f1_pop;     // load D1 from input fifo 1
    logic       f0_pop;     // load D0 from input fifo 0
    logic       f1_push;    // write result into output fifo 1
    logic       f0_push;    // write result into output fifo 0
    logic       sin_chain;  // serial in from neighbour, else routing
    logic       crc_en;     // left shift runs one crc/prs step
    logic [1:0] a1_wr;      // 0 keep, 1 result, 2 D1, 3 fifo 1
    logic [1:0] a0_wr;      // 0 keep, 1 result, 2 D0, 3 fifo 0
    logic [1:0] cin_sel;    // 0 zero, 1 routing, 2 saved, 3 neighbour
    pbd_shift_t shift;
    logic [1:0] srcb;       // 0 D0, 1 D1, 2 A0, 3 A1
    logic       srca;       // 0 A0, 1 A1
    pbd_func_t  func;
  } pbd_op_t;

  typedef struct packed {
    logic [1:0] cmp_pair;   // comparator operand pairing
    logic       chain_cond; // fold neighbour compare into ours
    logic       tmux;       // two register banks, alternate per step
    logic       f1_out;     // fifo 1 direction: 1 output, 0 input
    logic       f0_out;
    logic [2:0] msb;        // arithmetic/shift msb position
  } pbd_ctl_t;

  typedef struct packed {
    logic full;
    logic empty;
  } pbd_fifo_st_t;

endpackage

// File: hdl/pbd_fifo.sv
// Four-byte fifo used in either direction by the datapath
`timescale 1ns/1ns
`default_nettype none
module pbd_fifo
  import pbd_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         push,
  input  wire logic [7:0]   push_data,
  input  wire logic         pop,
  output logic [7:0]        head,
  output pbd_fifo_st_t      status
);

  typedef struct packed {
    logic [FIFO_DEP-1:0][7:0] mem;
    logic [2:0]               wp;
    logic [2:0]               rp;
    logic [7:0]               last;
  } pbd_fifo_state_t;

  pbd_fifo_state_t st_ff;
  pbd_fifo_state_t nxt_st;

  // ------------------------------------------------------------------
  // Flags and head
  // ------------------------------------------------------------------
  assign status.empty = (st_ff.wp == st_ff.rp);
  assign status.full  = (st_ff.wp == (st_ff.rp ^ 3'h4));
  // Empty fifo keeps returning the last value read
  assign head = status.empty ? st_ff.last : st_ff.mem[st_ff.rp[1:0]];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Write when full is dropped
    if (push && !status.full) begin
      nxt_st.mem[st_ff.wp[1:0]] = push_data;
      nxt_st.wp = st_ff.wp + 3'h1;
    end
    // Read when empty leaves pointers alone
    if (pop && !status.empty) begin
      nxt_st.last = st_ff.mem[st_ff.rp[1:0]];
      nxt_st.rp = st_ff.rp + 3'h1;
    end
    if (rst) begin
      nxt_st = '0;  // reset empties the fifo
    end
  end

  // Pointers move on rising edges only
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

endmodule // pbd_fifo
`default_nettype wire

// File: hdl/pbd_datapath.sv
// Programmable byte datapath of a logic tile, with an APB register port
`timescale 1ns/1ns
`default_nettype none
module pbd_datapath
  import pbd_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Routing fabric: [2:0] op select, [3] serial in, [4] carry, [5] step
  input  wire logic [5:0]   route_in,
  output logic [5:0]        route_out,
  // Neighbour chain, lower-order side in, higher-order side out
  input  wire logic         chain_ci,
  input  wire logic         chain_si,
  input  wire logic         chain_eq_in,
  input  wire logic         chain_lt_in,
  output logic              chain_co,
  output logic              chain_so,
  output logic              chain_eq,
  output logic              chain_lt
);

  typedef struct packed {
    logic [1:0][1:0][7:0]      acc;     // [bank][A0/A1]
    logic [1:0][7:0]           dreg;
    logic [1:0]                co;      // saved carry per bank
    logic [1:0]                so;      // saved shift-out per bank
    logic                      bank;
    logic [NUM_OPS-1:0]        [19:0] opcfg;
    pbd_ctl_t                  ctl;
    logic [7:0]                amask;
    logic [7:0]                omask;
    logic [1:0][7:0]           cmask;
    logic [7:0]                poly;
    logic [NUM_OUT-1:0][3:0]   outsel;
    logic [1:0]                rd_pop;  // bus read will pop fifo
    logic [5:0]                rout;
    logic [3:0]                chn;     // co, so, eq, lt
    logic                      rdy;
    logic [31:0]               rdat;
    logic                      err;
  } pbd_state_t;
  pbd_state_t   st_ff;
  pbd_state_t   nxt_st;
  logic [1:0]   f_push;
  logic [1:0]   f_pop;
  logic [1:0][7:0] f_wdata;
  logic [1:0][7:0] f_head;
  pbd_fifo_st_t [1:0] f_st;
  logic [1:0]   f_out;

  // ------------------------------------------------------------------
  // Two fifos, direction per fifo
  // ------------------------------------------------------------------
  assign f_out = {st_ff.ctl.f1_out, st_ff.ctl.f0_out};

  for (genvar gi = 0; gi < 2; gi++) begin : g_fifo
    pbd_fifo u_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .push      (f_push[gi]),
      .push_data (f_wdata[gi]),
      .pop       (f_pop[gi]),
      .head      (f_head[gi]),
      .status    (f_st[gi])
    );
  end

  // ------------------------------------------------------------------
  // Datapath step, condition generation and register port
  // ------------------------------------------------------------------
  always_comb begin
    pbd_op_t     op;
    logic        bk, step, cin, sin, co, so, ov, fb;
    logic        eq0, lt0, eq1, lt1, acc_ph, done, hit;
    logic [7:0]  a0, a1, wmask, mbit, opa, opb;
    logic [7:0]  res, sh, fin, c0b, c1a;
    logic [8:0]  sum;
    logic [15:0] cond;
    logic [4:0]  widx;
    logic [31:0] rd;
    nxt_st = st_ff;
    op     = pbd_op_t'(st_ff.opcfg[route_in[2:0]]);
    step   = route_in[5];
    bk     = st_ff.bank;
    a0     = st_ff.acc[bk][0];
    a1     = st_ff.acc[bk][1];
    f_push  = 2'b00;
    f_pop   = 2'b00;
    f_wdata = '0;
    // Width of arithmetic set by the msb position
    wmask = ONES8 >> (3'h7 - st_ff.ctl.msb);
    mbit  = 8'h01 << st_ff.ctl.msb;
    opa   = (op.srca ? a1 : a0) & wmask;
    case (op.srcb)
      2'h0:    opb = st_ff.dreg[0];
      2'h1:    opb = st_ff.dreg[1];
      2'h2:    opb = a0;
      default: opb = a1;
    endcase
    opb = opb & wmask;
    // Carry in: zero, routing carry, saved carry or neighbour carry
    case (op.cin_sel)
      2'h0:    cin = 1'b0;
      2'h1:    cin = route_in[4];
      2'h2:    cin = st_ff.co[bk];
      default: cin = chain_ci;
    endcase
    sin = op.sin_chain ? chain_si : route_in[3];
    // ALU
    case (op.func)
      FN_PASS: sum = {1'b0, opa};
      FN_INC:  sum = {1'b0, opa} + 9'h001;
      FN_DEC:  sum = {1'b0, opa} - 9'h001;
      FN_ADD:  sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      FN_SUB:  sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
      FN_XOR:  sum = {1'b0, opa ^ opb};
      FN_AND:  sum = {1'b0, opa & opb};
      default: sum = {1'b0, opa | opb};
    endcase
    co  = sum[{1'b0, st_ff.ctl.msb} + 4'h1];  // carry above the msb
    res = sum[7:0] & wmask & st_ff.amask;     // output masking
    // Signed overflow at the msb
    ov = 1'b0;
    if (op.func == FN_ADD) begin
      ov = (opa[st_ff.ctl.msb] == opb[st_ff.ctl.msb]) &&
           (res[st_ff.ctl.msb] != opa[st_ff.ctl.msb]);
    end else if (op.func == FN_SUB) begin
      ov = (opa[st_ff.ctl.msb] != opb[st_ff.ctl.msb]) &&
           (res[st_ff.ctl.msb] != opa[st_ff.ctl.msb]);
    end
    // Shifter, crc/prs step and OR mask, after the ALU
    fb = res[st_ff.ctl.msb] ^ sin;
    so = 1'b0;
    case (op.shift)
      SH_LEFT: begin
        so = res[st_ff.ctl.msb];
        if (op.crc_en) begin
          // One lfsr step per datapath step; sin from neighbour widens it
          sh = ({res[6:0], 1'b0} & wmask) ^
               (fb ? (st_ff.poly & wmask) : 8'h00);
        end else begin
          sh = {res[6:0], sin} & wmask;
        end
      end
      SH_RIGHT: begin
        so = res[0];
        sh = (res >> 1) | (sin ? mbit : 8'h00);
      end
      SH_SWAP: sh = {res[3:0], res[7:4]};
      default: sh = res;
    endcase
    fin = sh | st_ff.omask;
    // Masked comparators, selectable pairings
    c0b = st_ff.ctl.cmp_pair[0] ? a1 : st_ff.dreg[0];
    c1a = st_ff.ctl.cmp_pair[1] ? a0 : a1;
    eq0 = (a0 & st_ff.cmask[0]) == (c0b & st_ff.cmask[0]);
    lt0 = (a0 & st_ff.cmask[0]) <  (c0b & st_ff.cmask[0]);
    eq1 = (c1a & st_ff.cmask[1]) == (st_ff.dreg[1] & st_ff.cmask[1]);
    lt1 = (c1a & st_ff.cmask[1]) <  (st_ff.dreg[1] & st_ff.cmask[1]);
    // Fold lower-order neighbour compare into ours
    if (st_ff.ctl.chain_cond) begin
      lt0 = lt0 | (eq0 & chain_lt_in);
      eq0 = eq0 & chain_eq_in;
    end
    // Condition vector
    cond         = '0;
    cond[CN_CE0] = eq0;
    cond[CN_CL0] = lt0;
    cond[CN_Z0]  = (a0 & wmask) == 8'h00;
    cond[CN_Z1]  = (a1 & wmask) == 8'h00;
    cond[CN_FF0] = (a0 & wmask) == wmask;
    cond[CN_FF1] = (a1 & wmask) == wmask;
    cond[CN_CE1] = eq1;
    cond[CN_CL1] = lt1;
    cond[CN_OV]  = ov;
    cond[CN_CO]  = st_ff.co[bk];
    cond[CN_SO]  = st_ff.so[bk];
    cond[CN_F0E] = f_st[0].empty;
    cond[CN_F0F] = f_st[0].full;
    cond[CN_F1E] = f_st[1].empty;
    cond[CN_F1F] = f_st[1].full;
    cond[CN_FB]  = fb;
    // Six routing outputs, each picks one condition
    for (int i = 0; i < NUM_OUT; i++) begin
      nxt_st.rout[i] = cond[st_ff.outsel[i]];
    end
    nxt_st.chn = {co, so, eq0, lt0};  // to higher neighbour
    // Accumulators and saved carry/shift-out on a step
    if (step) begin
      case (op.a0_wr)
        2'h1:    nxt_st.acc[bk][0] = fin;
        2'h2:    nxt_st.acc[bk][0] = st_ff.dreg[0];
        2'h3:    nxt_st.acc[bk][0] = f_head[0];
        default: nxt_st.acc[bk][0] = a0;
      endcase
      case (op.a1_wr)
        2'h1:    nxt_st.acc[bk][1] = fin;
        2'h2:    nxt_st.acc[bk][1] = st_ff.dreg[1];
        2'h3:    nxt_st.acc[bk][1] = f_head[1];
        default: nxt_st.acc[bk][1] = a1;
      endcase
      nxt_st.co[bk] = co;
      nxt_st.so[bk] = so;
      if (st_ff.ctl.tmux) begin
        nxt_st.bank = ~bk;  // alternate register banks
      end
      // Datapath side of each fifo
      f_push  = f_out & {op.f1_push, op.f0_push};
      f_pop   = ~f_out & ({op.f1_pop, op.f0_pop} |
                          {op.a1_wr == 2'h3, op.a0_wr == 2'h3});
      f_wdata = {fin, fin};
      if (!f_out[0] && op.f0_pop) begin
        nxt_st.dreg[0] = f_head[0];
      end
      if (!f_out[1] && op.f1_pop) begin
        nxt_st.dreg[1] = f_head[1];
      end
    end
    // APB: one wait state, answer registered, effect at completion
    acc_ph = psel && penable;
    done   = acc_ph && st_ff.rdy;
    widx   = paddr[6:2];
    hit    = (paddr[1:0] == 2'b00) &&
             ((paddr <= OFS_STATUS) ||
              ((paddr >= OFS_OPCFG) && (paddr[7:5] == 3'h2)));
    case (paddr)
      OFS_A0:     rd = {24'h0, st_ff.acc[0][0]};
      OFS_A1:     rd = {24'h0, st_ff.acc[0][1]};
      OFS_D0:     rd = {24'h0, st_ff.dreg[0]};
      OFS_D1:     rd = {24'h0, st_ff.dreg[1]};
      OFS_F0:     rd = {24'h0, f_head[0]};
      OFS_F1:     rd = {24'h0, f_head[1]};
      OFS_CTL:    rd = {23'h0, st_ff.ctl};
      OFS_MASK:   rd = {st_ff.cmask, st_ff.omask, st_ff.amask};
      OFS_POLY:   rd = {24'h0, st_ff.poly};
      OFS_OUTSEL: rd = {8'h0, st_ff.outsel};
      OFS_STATUS: rd = {15'h0, st_ff.bank, cond};
      default:    rd = (hit ? {12'h0, st_ff.opcfg[widx[2:0]]} : 32'h0);
    endcase
    nxt_st.rdy = acc_ph && !st_ff.rdy;
    nxt_st.rdat = 32'h0;  // answer stands one cycle only
    nxt_st.err  = 1'b0;
    if (acc_ph && !st_ff.rdy) begin
      nxt_st.rdat   = pwrite ? 32'h0 : rd;
      nxt_st.err    = !hit;
      nxt_st.rd_pop = {!pwrite && f_out[1] && !f_st[1].empty &&
                       (paddr == OFS_F1),
                       !pwrite && f_out[0] && !f_st[0].empty &&
                       (paddr == OFS_F0)};
    end
    if (done) begin
      nxt_st.rd_pop = 2'b00;
      // Bus side of each fifo
      f_pop = f_pop | st_ff.rd_pop;
      if (pwrite && (paddr == OFS_F0) && !f_out[0]) begin
        f_push[0]  = 1'b1;
        f_wdata[0] = pwdata[7:0];
      end
      if (pwrite && (paddr == OFS_F1) && !f_out[1]) begin
        f_push[1]  = 1'b1;
        f_wdata[1] = pwdata[7:0];
      end
      if (pwrite) begin
        case (paddr)
          OFS_A0:     nxt_st.acc[0][0] = pwdata[7:0];
          OFS_A1:     nxt_st.acc[0][1] = pwdata[7:0];
          OFS_D0:     nxt_st.dreg[0]   = pwdata[7:0];
          OFS_D1:     nxt_st.dreg[1]   = pwdata[7:0];
          OFS_CTL:    nxt_st.ctl       = pbd_ctl_t'(pwdata[8:0]);
          OFS_MASK:   {nxt_st.cmask, nxt_st.omask, nxt_st.amask} = pwdata;
          OFS_POLY:   nxt_st.poly      = pwdata[7:0];
          OFS_OUTSEL: nxt_st.outsel    = pwdata[23:0];
          default: begin
            if (hit && (paddr >= OFS_OPCFG)) begin
              nxt_st.opcfg[widx[2:0]] = pwdata[19:0];
            end
          end
        endcase
      end
    end
    // Reset clears accumulators and defaults the configuration
    if (rst) begin
      nxt_st           = '0;
      nxt_st.ctl.msb   = MSB_RST;
      nxt_st.amask     = AMASK_RST;
    end
  end
  // State register, rising edge only
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  // ------------------------------------------------------------------
  // Outputs straight from the state register
  // ------------------------------------------------------------------
  assign pready    = st_ff.rdy;
  assign prdata    = st_ff.rdat;
  assign pslverr   = st_ff.err;
  assign route_out = st_ff.rout;
  assign chain_co  = st_ff.chn[3];
  assign chain_so  = st_ff.chn[2];
  assign chain_eq  = st_ff.chn[1];
  assign chain_lt  = st_ff.chn[0];

endmodule // pbd_datapath
`default_nettype wire

// File: sim/pbd_datapath_assertions.sv
// Port checker for the programmable byte datapath
`timescale 1ns/1ns
`default_nettype none
module pbd_datapath_assertions
  import pbd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [5:0]  route_out,
  input wire logic        chain_co
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----
  // Register bus answers
  // ----
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_in_access_a: assert property (
    pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  one_wait_a: assert property (
    psel && penable && !pready && !$past(penable) |=> pready)
    else $error("answer not one cycle after access start");
  write_data_zero_a: assert property (
    pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on a write");
  err_needs_ready_a: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("error flag without answer or with data");
  unmapped_err_a: assert property (
    pready && (paddr[1:0] != 2'h0 || paddr > 8'h5c) |-> pslverr)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (
    pready && paddr[1:0] == 2'h0 && paddr <= OFS_STATUS |-> !pslverr)
    else $error("mapped register refused");

  // ----
  // Reset state of outputs
  // ----
  reset_quiet_a: assert property (
    $fell(rst) |-> !pready && route_out == 6'h0 && !chain_co)
    else $error("outputs not cleared by reset");

  // Main scenarios
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property ($changed(route_out));
endmodule  // pbd_datapath_assertions

bind pbd_datapath pbd_datapath_assertions u_chk (
  .ref_clk  (ref_clk),
  .rst      (rst),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .paddr    (paddr),
  .pready   (pready),
  .prdata   (prdata),
  .pslverr  (pslverr),
  .route_out(route_out),
  .chain_co (chain_co)
);
`default_nettype wire

// File: sim/pbd_fabric.sv
// Routing fabric model: operation select and serial bits
`timescale 1ns/1ns
`default_nettype none
module pbd_fabric
  import pbd_pkg::*;
(
  input  wire logic       go,
  input  wire logic [2:0] op,
  input  wire logic [3:0] rnd,
  output logic [5:0]      route_in,
  output logic            chain_ci,
  output logic            chain_si,
  output logic            chain_eq_in,
  output logic            chain_lt_in
);
  // Step, carry, serial in and op select each cycle
  assign route_in    = {go, rnd[1:0], op};
  // Neighbour chain bits change every cycle
  assign chain_ci    = rnd[2];
  assign chain_si    = rnd[3];
  assign chain_eq_in = rnd[0];
  assign chain_lt_in = rnd[1];
endmodule  // pbd_fabric
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the programmable byte datapath
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
  errors++; $display("Error %s expected %h seen %h", nm, e, s); end end
module tb_top
  import pbd_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, go = 1'b0, er;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, a, d, last;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] noise = 32'h9fe5, seed = 32'h9fe5;
  logic        pready, pslverr;
  logic [2:0]  op = 3'h0;
  logic [5:0]  route_in, route_out;
  logic        ci, si, eqi, lti;
  logic        chain_co, chain_so, chain_eq, chain_lt, sb;
  logic [8:0]  r9;
  logic [7:0]  fq[$];
  int          errors = 0, check_count = 0;

  // ----
  // Model and helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [8:0] alu(int f, int x, int y);
    int r;
    case (f)
      1: r = x + 1;
      2: r = x - 1;
      3: r = x + y;
      4: r = x - y;
      5: r = x ^ y;
      6: r = x & y;
      7: r = x | y;
      default: r = x;
    endcase
    return r[8:0];  // carry or borrow in bit 8
  endfunction

  // Outputs select f0 empty/full, f1 empty/full; f1 stays empty
  function automatic logic [5:0] rexp();
    logic e0;
    e0 = fq.size() == 0;
    return {1'b1, e0, 1'b0, 1'b1, fq.size() == 4, e0};
  endfunction

  task automatic complete_run();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    n = 0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic step(input logic [2:0] s);
    @(posedge ref_clk);
    go <= 1'b1;
    op <= s;
    @(posedge ref_clk);
    sb = noise[0];  // Serial in seen by this step
    go <= 1'b0;
  endtask

  // ----
  // Clock, noise and instances
  // ----
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) noise <= lfsr(noise);

  pbd_fabric fab (.go(go), .op(op), .rnd(noise[3:0]),
    .route_in(route_in), .chain_ci(ci), .chain_si(si),
    .chain_eq_in(eqi), .chain_lt_in(lti));

  pbd_datapath DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .route_in(route_in), .route_out(route_out),
    .chain_ci(ci), .chain_si(si), .chain_eq_in(eqi),
    .chain_lt_in(lti), .chain_co(chain_co), .chain_so(chain_so),
    .chain_eq(chain_eq), .chain_lt(chain_lt));

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CTL, 32'h0);
    `CHK("ctl", 32'h7, rd)
    apb(1'b0, OFS_MASK, 32'h0);
    `CHK("mask", 32'hff, rd)
    apb(1'b0, 8'h62, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, OFS_OUTSEL, 32'h00dbedcb);
    repeat (2) @(posedge ref_clk);
    `CHK("route empty", rexp(), route_out)
    for (int f = 0; f < 8; f++) apb(1'b1, OFS_OPCFG + 8'(4 * f), 32'h400 | f);
    apb(1'b1, OFS_MASK, 32'h00ff00ff);
    // Every function on random operands
    for (int f = 0; f < 8; f++) begin
      seed = lfsr(seed);
      a = seed[7:0];
      d = seed[15:8];
      apb(1'b1, OFS_A0, {24'h0, a});
      apb(1'b1, OFS_D0, {24'h0, d});
      step(3'(f));
      apb(1'b0, OFS_A0, 32'h0);
      r9 = alu(f, a, d);
      `CHK("alu", {24'h0, r9[7:0]}, rd)
      `CHK("chain eq", r9[7:0] == d, chain_eq)
      `CHK("chain lt", r9[7:0] < d, chain_lt)
      r9 = alu(f, r9[7:0], d);
      `CHK("carry out", r9[8], chain_co)
      `CHK("shift out", 1'b0, chain_so)
    end
    // One crc step on a random serial bit
    apb(1'b1, OFS_POLY, 32'h1d);
    apb(1'b1, OFS_OPCFG + 8'h8, 32'h4440);
    apb(1'b1, OFS_A0, {24'h0, a});
    step(3'h2);
    apb(1'b0, OFS_A0, 32'h0);
    last = {a[6:0], 1'b0} ^ ((a[7] ^ sb) ? 8'h1d : 8'h00);
    `CHK("crc", {24'h0, last}, rd)
    // Nibble swap, then add under a 4-bit output mask
    apb(1'b1, OFS_OPCFG, 32'h4c0);
    apb(1'b1, OFS_A0, 32'h3c);
    step(3'h0);
    apb(1'b0, OFS_A0, 32'h0);
    `CHK("swap", 32'hc3, rd)
    apb(1'b1, OFS_MASK, 32'h0f);
    step(3'h3);
    apb(1'b0, OFS_A0, 32'h0);
    `CHK("masked", {23'h0, alu(3, 8'hc3, d) & 9'h00f}, rd)
    apb(1'b1, OFS_MASK, 32'hff);
    // Input fifo: overfill, then pop past empty
    repeat (5) begin
      seed = lfsr(seed);
      apb(1'b1, OFS_F0, {24'h0, seed[7:0]});
      if (fq.size() < 4) fq.push_back(seed[7:0]);
    end
    repeat (2) @(posedge ref_clk);
    `CHK("route full", rexp(), route_out)
    apb(1'b1, OFS_OPCFG + 8'h4, 32'h40c00);
    repeat (5) begin
      if (fq.size() > 0) last = fq.pop_front();
      step(3'h1);
      apb(1'b0, OFS_A0, 32'h0);
      `CHK("fifo pop", {24'h0, last}, rd)
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("empty", 1'b1, rd[CN_F0E])
    complete_run();
  end
endmodule  // tb_top
`default_nettype wire
